/* src/keypad_scanner.sv */
// Notes on behaviour
// - Host clear resets valid flag and key code unless a press is taken that cycle
// - Valid rises after debounce, holds until clear
// - Row drive is inverted one-hot of counter
// - Row counter steps continuously near 31 Hz
// - Columns active low; all ones means idle
// - Accept after three equal debounce samples
// - Row step eight times slower than debounce
// - Flag and key code captured together
// - Inverted column priority-encoded to two bits
// - Row part is current scan counter value
// - Row in bits 3..2, column in 1..0
// - Key code held while flag high
// - Multiple simultaneous keys on one row are ignored
`timescale 1ns/1ps
`default_nettype none

`include "keypad_scanner_params.svh"

module keypad_scanner
  import keypad_scanner_pkg::*;
#(
  parameter int DEB_TICKS = `DEB_DIV
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       hostClear,
  input  wire logic [3:0] colSense,
  output var  logic [3:0] rowDrive,
  output var  key_code_t  keyCode,
  output var  logic       pressValidFlag
);

  localparam logic [4:0]  PRE_LAST  = 5'(`PRE_CYCLES - 1);
  localparam logic [11:0] DEB_LAST  = 12'(DEB_TICKS - 1);
  localparam logic [2:0]  SCAN_LAST = 3'(`SCAN_DIV - 1);

  // ****************************************************
  // Tick dividers
  // ****************************************************
  logic [4:0]  preCount_reg;
  logic [4:0]  preCount_next;
  logic [11:0] debCount_reg;
  logic [11:0] debCount_next;
  logic [2:0]  scanDiv_reg;
  logic [2:0]  scanDiv_next;
  logic        baseTick;
  logic        debTick;
  logic        scanTick;

  // Base 1 MHz tick, then debounce tick, then row step
  assign baseTick = (preCount_reg == PRE_LAST);
  assign debTick  = baseTick && (debCount_reg == DEB_LAST);
  assign scanTick = debTick && (scanDiv_reg == SCAN_LAST);

  always_comb begin
    preCount_next = baseTick ? 5'h00 : preCount_reg + 5'h01;
    debCount_next = debCount_reg;
    scanDiv_next  = scanDiv_reg;
    if (baseTick) begin
      debCount_next = debTick ? 12'h000 : debCount_reg + 12'h001;
    end
    if (debTick) begin
      scanDiv_next = scanDiv_reg + 3'h1; // Wraps after eight samples
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preCount_reg <= 5'h00;
      debCount_reg <= 12'h000;
      scanDiv_reg  <= 3'h0;
    end else if (ce) begin
      preCount_reg <= preCount_next;
      debCount_reg <= debCount_next;
      scanDiv_reg  <= scanDiv_next;
    end
  end

  // ****************************************************
  // Row scan
  // ****************************************************
  logic [1:0] scanCount_reg;
  logic [1:0] scanCount_next;
  logic [3:0] rowDrive_reg;
  logic [3:0] rowDrive_next;

  // Free-running; no trigger needed to keep scanning
  always_comb begin
    scanCount_next = scanCount_reg;
    if (scanTick) begin
      scanCount_next = scanCount_reg + 2'h1;
    end
    rowDrive_next = ~(4'h1 << scanCount_next);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scanCount_reg <= `ROW_CNT_RESET;
      rowDrive_reg  <= ~4'h1;
    end else if (ce) begin
      scanCount_reg <= scanCount_next;
      rowDrive_reg  <= rowDrive_next;
    end
  end

  assign rowDrive = rowDrive_reg;

  // ****************************************************
  // Debounce
  // ****************************************************
  logic [3:0] colNewest;
  logic       colStable;

  // History is flushed on a row step so that samples from two
  // rows can never be mistaken for one steady press
  debounce_stage #(
    .WIDTH (4),
    .DEPTH (`DEB_SAMPLES)
  ) u_debounce (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .sampleEn (debTick),
    .flush    (scanTick),
    .din      (colSense),
    .newest   (colNewest),
    .stable   (colStable)
  );

  // ****************************************************
  // Column encode and press qualification
  // ****************************************************
  logic [3:0] colActive;
  logic       singleKey;
  logic [1:0] colCode;
  logic       goodNow;
  logic       goodPrev_reg;
  logic       goodPrev_next;
  logic       acceptPulse;

  // Inverted, so a pressed column reads as a one
  assign colActive = ~colNewest;
  // Exactly one column low; none or several is no press
  assign singleKey = (colActive != 4'h0)
                   && ((colActive & (colActive - 4'h1)) == 4'h0);

  always_comb begin
    casez (colActive)
      4'b???1: colCode = 2'h0;
      4'b??10: colCode = 2'h1;
      4'b?100: colCode = 2'h2;
      default: colCode = 2'h3;
    endcase
  end

  // A held key is reported once per pass over its row, on the first agreeing sample
  assign goodNow     = colStable && singleKey;
  assign acceptPulse = debTick && goodNow && !goodPrev_reg;

  always_comb begin
    goodPrev_next = goodPrev_reg;
    if (debTick) begin
      goodPrev_next = goodNow;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      goodPrev_reg <= 1'b0;
    end else if (ce) begin
      goodPrev_reg <= goodPrev_next;
    end
  end

  // ****************************************************
  // Report state, flag and key code
  // ****************************************************
  report_state_t state_reg;
  report_state_t state_next;
  key_code_t     keyCode_reg;
  key_code_t     keyCode_next;
  logic          acceptTake;

  // Presses while reported are dropped, not queued
  assign acceptTake = acceptPulse && (state_reg == WAIT_PRESS);

  // A press in the clear cycle wins over the clear
  always_comb begin
    state_next   = state_reg;
    keyCode_next = keyCode_reg;
    case (state_reg)
      WAIT_PRESS: begin
        if (acceptTake) begin
          state_next       = KEY_REPORTED;
          keyCode_next.row = scanCount_reg;
          keyCode_next.col = colCode;
        end else if (hostClear) begin
          keyCode_next = `KEY_RESET;
        end
      end
      KEY_REPORTED: begin
        if (hostClear) begin
          state_next   = WAIT_PRESS;
          keyCode_next = `KEY_RESET;
        end
      end
      default: begin
        state_next = WAIT_PRESS;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= WAIT_PRESS;
      keyCode_reg <= `KEY_RESET;
    end else if (ce) begin
      state_reg   <= state_next;
      keyCode_reg <= keyCode_next;
    end
  end

  // Flag is the state itself, usable as a level interrupt
  assign pressValidFlag = (state_reg == KEY_REPORTED);
  assign keyCode        = keyCode_reg;

  // ****************************************************
  // Checks
  // ****************************************************
  sequence s_accept;
    ce && acceptTake;
  endsequence

  sequence s_reported;
    pressValidFlag && keyCode.row == $past(scanCount_reg);
  endsequence

  a_row_decode: assert property (
    @(posedge clk) disable iff (!rstn)
    rowDrive == ~(4'h1 << scanCount_reg))
    else $error("row drive does not match scan counter");

  a_row_step_tick: assert property (
    @(posedge clk) disable iff (!rstn)
    !(ce && scanTick) |=> $stable(scanCount_reg))
    else $error("row counter moved without a scan tick");

  a_scan_on_deb: assert property (
    @(posedge clk) disable iff (!rstn)
    scanTick |-> debTick && scanDiv_reg == 3'h7)
    else $error("row step not aligned to eighth debounce tick");

  a_flag_capture: assert property (
    @(posedge clk) disable iff (!rstn)
    s_accept |=> s_reported)
    else $error("accepted press not captured with flag");

  a_flag_cause: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(pressValidFlag) |-> $past(acceptTake)
      && keyCode.col == $past(colCode))
    else $error("flag rose without an accepted press");

  a_clear_drops: assert property (
    @(posedge clk) disable iff (!rstn)
    ce && hostClear && !acceptTake |=> !pressValidFlag
      && keyCode == `KEY_RESET)
    else $error("host clear did not reset flag and code");

  a_code_holds: assert property (
    @(posedge clk) disable iff (!rstn)
    pressValidFlag && !hostClear |=> pressValidFlag
      && $stable(keyCode))
    else $error("key code changed while flag high");

  a_multi_ignored: assert property (
    @(posedge clk) disable iff (!rstn)
    ce && debTick && !singleKey && !pressValidFlag
      |=> !pressValidFlag)
    else $error("idle or multiple keys raised the flag");

  a_col_encode: assert property (
    @(posedge clk) disable iff (!rstn)
    singleKey |-> colActive[colCode])
    else $error("column code does not match the active column");

  a_row_matches: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(pressValidFlag) |-> $past(rowDrive) == ~(4'h1 << keyCode.row))
    else $error("reported row differs from the row under test");

  // Row period counted in core cycles; check helper only
  localparam logic [19:0] ROW_LAST =
    20'(`PRE_CYCLES * DEB_TICKS * `SCAN_DIV - 1);
  logic [19:0] rowAge_reg;
  logic [19:0] rowAge_next;

  always_comb begin
    rowAge_next = rowAge_reg + 20'h00001;
    if (scanTick) begin
      rowAge_next = 20'h00000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rowAge_reg <= 20'h00000;
    end else if (ce) begin
      rowAge_reg <= rowAge_next;
    end
  end

  a_row_period: assert property (
    @(posedge clk) disable iff (!rstn)
    ce |-> scanTick == (rowAge_reg == ROW_LAST))
    else $error("row step not at the expected period");

endmodule

`default_nettype wire

/* src/keypad_scanner_params.svh */
`ifndef KEYPAD_SCANNER_PARAMS_SVH
`define KEYPAD_SCANNER_PARAMS_SVH

// ****************************************************
// Timing
// ****************************************************
// Core clock period and the internal 1 MHz base tick period
`define CLK_PERIOD_NS   50
`define BASE_PERIOD_NS  1000
// Core cycles per base tick, rounded up
`define PRE_CYCLES ((`BASE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Base ticks per debounce sample (about 244 Hz)
`define DEB_DIV         4096
// Debounce samples per row step (about 30.5 Hz)
`define SCAN_DIV        8
// Equal samples needed to accept a press
`define DEB_SAMPLES     3

// ****************************************************
// Values and fields
// ****************************************************
`define COL_IDLE        4'hF
`define ROW_IDLE        4'hF
`define ROW_CNT_RESET   2'h0
`define KEY_RESET       4'h0
`define KEY_ROW_MSB     3
`define KEY_ROW_LSB     2
`define KEY_COL_MSB     1
`define KEY_COL_LSB     0

`endif

/* src/keypad_scanner_pkg.sv */
package keypad_scanner_pkg;

  // Key code: row in the upper pair, column in the lower pair
  typedef struct packed {
    logic [1:0] row;
    logic [1:0] col;
  } key_code_t;

  // Report state of the valid flag
  typedef enum logic {
    WAIT_PRESS,
    KEY_REPORTED
  } report_state_t;

endpackage

/* src/debounce_stage.sv */
`timescale 1ns/1ps
`default_nettype none

`include "keypad_scanner_params.svh"

module debounce_stage #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             sampleEn,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] newest,
  output var  logic             stable
);

  logic [WIDTH-1:0] hist_reg  [DEPTH];
  logic [WIDTH-1:0] hist_next [DEPTH];

  // ****************************************************
  // Sample history
  // ****************************************************
  // Flush fills with idle so stale samples never match
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      hist_next[i] = hist_reg[i];
    end
    if (flush) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_next[i] = WIDTH'(`COL_IDLE);
      end
    end else if (sampleEn) begin
      hist_next[0] = din;
      for (int i = 1; i < DEPTH; i++) begin
        hist_next[i] = hist_reg[i-1];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_reg[i] <= WIDTH'(`COL_IDLE);
      end
    end else if (ce) begin
      hist_reg <= hist_next;
    end
  end

  // ****************************************************
  // Agreement of all samples
  // ****************************************************
  always_comb begin
    stable = 1'b1;
    for (int i = 1; i < DEPTH; i++) begin
      if (hist_reg[i] != hist_reg[0]) begin
        stable = 1'b0;
      end
    end
  end

  assign newest = hist_reg[0];

  // ****************************************************
  // Checks
  // ****************************************************
  // Samples taken since the last flush, saturating; check helper only
  logic [7:0] sinceFlush_reg;
  logic [7:0] sinceFlush_next;

  always_comb begin
    sinceFlush_next = sinceFlush_reg;
    if (flush) begin
      sinceFlush_next = 8'h00;
    end else if (sampleEn && sinceFlush_reg < 8'(DEPTH)) begin
      sinceFlush_next = sinceFlush_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sinceFlush_reg <= 8'h00;
    end else if (ce) begin
      sinceFlush_reg <= sinceFlush_next;
    end
  end

  // A pressed pattern needs DEPTH fresh samples after a flush
  a_flush_breaks_run: assert property (
    @(posedge clk) disable iff (!rstn)
    stable && newest != WIDTH'(`COL_IDLE)
    |-> sinceFlush_reg >= 8'(DEPTH))
    else $error("debounce run accepted across a flush");

endmodule

`default_nettype wire

/* bench/keypad_matrix_model.sv */
`timescale 1ns/1ps
`default_nettype none

module keypad_matrix_model (
  input  wire logic [3:0]  rowDrive,
  input  wire logic [15:0] keyDown,
  output var  logic [3:0]  colSense
);
  // Passive switches, columns pulled up: an open column reads 1
  always_comb begin
    colSense = 4'hF;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        if (!rowDrive[r] && keyDown[r*4+c]) begin
          colSense[c] = 1'b0;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* bench/keypad_scanner_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module keypad_scanner_bench;
  import keypad_scanner_pkg::*;
  // Short divider keeps the run small; row step is 20*DEB*8 cycles
  localparam int DEB  = 4;
  localparam int STEP = 20 * DEB * 8;

  logic        clk;
  logic        rstn;
  logic        ce;
  logic        hostClear;
  logic [15:0] keyDown;
  logic [3:0]  colSense;
  logic [3:0]  rowDrive;
  key_code_t   keyCode;
  logic        pressValidFlag;
  logic        seen;
  int          err_total;
  int          n_compared;

  keypad_scanner #(.DEB_TICKS(DEB)) u_keypad_scanner (
    .clk(clk), .rstn(rstn), .ce(ce), .hostClear(hostClear),
    .colSense(colSense), .rowDrive(rowDrive), .keyCode(keyCode),
    .pressValidFlag(pressValidFlag));

  keypad_matrix_model u_keypad_matrix_model (
    .rowDrive(rowDrive), .keyDown(keyDown), .colSense(colSense));

  // Single core clock, rising edge active
  always #25 clk = ~clk;

  // ****************************************************
  // Compare and helper tasks
  // ****************************************************
  task automatic check4(input string what, input logic [3:0] exp,
                        input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp,
                        input logic got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_count(input string what, input int exp,
                             input int got);
    n_compared++;
    if (got != exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Poll the flag as a host would; bounded by one full scan plus debounce
  task automatic wait_flag();
    seen = 1'b0;
    for (int i = 0; i < 3200 && !seen; i++) begin
      @(negedge clk);
      seen = (pressValidFlag === 1'b1);
    end
  endtask

  task automatic host_clear();
    @(negedge clk);
    hostClear = 1'b1;
    @(negedge clk);
    check1("flag after clear", 1'b0, pressValidFlag);
    check4("code after clear", 4'h0, keyCode);
    hostClear = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  // Row walk: values and spacing; idle columns never raise the flag
  task automatic t_row_scan();
    logic [3:0] seq [4] = '{4'hD, 4'hB, 4'h7, 4'hE};
    logic [3:0] last;
    int n;
    check4("row at reset", 4'hE, rowDrive);
    check1("flag at reset", 1'b0, pressValidFlag);
    for (int i = 0; i < 4; i++) begin
      last = rowDrive;
      n = 0;
      while (rowDrive === last && n < 2 * STEP) begin
        @(negedge clk);
        n++;
      end
      check4("row step", seq[i], rowDrive);
      if (i > 0) check_count("row hold", STEP, n);
    end
    check1("flag idle", 1'b0, pressValidFlag);
  endtask

  // Every key in turn; expected code is row*4+col
  task automatic t_each_key();
    for (int k = 0; k < 16; k++) begin
      keyDown = 16'h1 << k;
      wait_flag();
      check1("flag on press", 1'b1, seen);
      check4("key code", k[3:0], keyCode);
      keyDown = 16'h0;
      host_clear();
    end
  endtask

  // Second press while reported must not disturb flag or code
  task automatic t_hold();
    keyDown = 16'h0040;
    wait_flag();
    check1("flag on hold press", 1'b1, seen);
    keyDown = 16'h0200;
    repeat (3000) @(negedge clk);
    check1("flag held", 1'b1, pressValidFlag);
    check4("code held", 4'h6, keyCode);
    keyDown = 16'h0;
    host_clear();
  endtask

  // Two keys on one row pull two columns low together
  task automatic t_two_keys();
    keyDown = 16'h0003;
    repeat (3000) @(negedge clk);
    check1("flag two keys", 1'b0, pressValidFlag);
    check4("code two keys", 4'h0, keyCode);
    keyDown = 16'h0;
  endtask

  // Clock enable low freezes the row walk and the report path
  task automatic t_freeze();
    logic [3:0] last;
    int n;
    last = rowDrive;
    keyDown = 16'h1111;
    ce = 1'b0;
    repeat (2 * STEP) @(negedge clk);
    check4("row frozen", last, rowDrive);
    check1("flag frozen", 1'b0, pressValidFlag);
    keyDown = 16'h0;
    ce = 1'b1;
    n = 0;
    while (rowDrive === last && n < 2 * STEP) begin
      @(negedge clk);
      n++;
    end
    check1("row resumes", 1'b1, n > 0 && n <= STEP);
  endtask

  // Contact toggles once per debounce sample, then settles
  task automatic t_bounce();
    for (int i = 0; i < 40; i++) begin
      keyDown = (i % 2) ? 16'h0 : 16'h0400;
      repeat (20 * DEB) @(negedge clk);
    end
    check1("flag bouncing", 1'b0, pressValidFlag);
    keyDown = 16'h0400;
    wait_flag();
    check4("code settled", 4'hA, keyCode);
    keyDown = 16'h0;
    host_clear();
  endtask

  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    hostClear = 1'b0;
    keyDown = 16'h0;
    err_total = 0;
    n_compared = 0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    t_row_scan();
    t_each_key();
    t_hold();
    t_two_keys();
    t_freeze();
    t_bounce();
    report_and_stop();
  end

  // Normal run is near 28.5k cycles; give it headroom
  initial begin
    #(60000 * 50);
    err_total++;
    report_and_stop();
  end
endmodule

`default_nettype wire
